// *** iau_defs.svh ***
// Constants of the integer arithmetic unit: register offsets, field positions,
// reset values and decimal adjust figures.
// Assumes inclusion by bare name from each file that needs it.
`ifndef IAU_DEFS_SVH
`define IAU_DEFS_SVH

`define IAU_AXI_AW        4
`define IAU_OFS_FLAGS     4'h0
`define IAU_OFS_STATUS    4'h4
`define IAU_ST_BUSY_BIT   0
`define IAU_ST_DERR_BIT   1
`define IAU_FLAGS_RST     6'h00
`define IAU_RESP_OKAY     2'b00
`define IAU_RESP_SLVERR   2'b10
`define IAU_DIGIT_MAX     4'h9
`define IAU_NIB_ADJ       8'h06
`define IAU_HI_ADJ        8'h60
`define IAU_PACKED_MAX    8'h99
`define IAU_TEN           8'h0a

`endif

// *** iau_pkg.sv ***
// Types shared by the integer arithmetic unit: opcodes, flags, request and
// answer bundles, control states.
// Assumes nothing of its surroundings.
package iau_pkg;

	typedef enum logic [4:0] {
		ADD_OP,
		ADD_CARRY_OP,
		PLUS_ONE_OP,
		ASCII_ADD_FIX,
		PACKED_BCD_ADD_FIX,
		DIFFERENCE_OP,
		DIFFERENCE_WITH_BORROW,
		MINUS_ONE_OP,
		TWOS_COMPLEMENT_OP,
		COMPARE_OP,
		ASCII_DIFFERENCE_FIX,
		PACKED_BCD_DIFFERENCE_FIX,
		UNSIGNED_PRODUCT_OP,
		SIGNED_PRODUCT_OP,
		ASCII_PRODUCT_FIX,
		UNSIGNED_QUOTIENT_OP,
		SIGNED_QUOTIENT_OP,
		ASCII_QUOTIENT_PREP,
		BYTE_SIGN_EXTEND,
		WORD_SIGN_EXTEND
	} iau_op_e;

	typedef struct packed {
		logic overflow_flag;
		logic sign_flag;
		logic zero_flag;
		logic half_carry_flag;
		logic parity_flag;
		logic carry_flag;
	} iau_flags_s;

	typedef struct packed {
		iau_op_e     op;
		logic        word;
		logic [15:0] dst;
		logic [15:0] src;
		logic [15:0] accumulator_word;
		logic [15:0] extension_word;
	} iau_req_s;

	typedef struct packed {
		logic [15:0] dst;
		logic [15:0] accumulator_word;
		logic [15:0] extension_word;
		logic        wr_dst;
		logic        wr_acc;
		logic        wr_ext;
	} iau_rsp_s;

	typedef enum logic {
		ST_IDLE,
		ST_DIVIDE
	} iau_state_e;

endpackage

// *** iau_decimal_adjust.sv ***
// Decimal adjust of the accumulator low byte after addition or subtraction,
// ASCII (unpacked) and packed forms; purely combinational.
// Assumes the caller supplies the current half-carry and carry flags.
`timescale 1ns/1ps
`default_nettype none
`include "iau_defs.svh"

module iau_decimal_adjust
	import iau_pkg::*;
(
	input  wire iau_pkg::iau_op_e op_i,
	input  wire logic [7:0]       al_i,
	input  wire logic             af_i,
	input  wire logic             cf_i,
	output logic [7:0]            al_o,
	output logic                  af_o,
	output logic                  cf_o
);
	logic       lo_adj;
	logic       hi_adj;
	logic [8:0] s1;

	always_comb
	begin
		lo_adj = (al_i[3:0] > `IAU_DIGIT_MAX) | af_i;
		hi_adj = (al_i > `IAU_PACKED_MAX) | cf_i;
		s1     = {1'b0, al_i};
		al_o   = al_i;
		af_o   = af_i;
		cf_o   = cf_i;
		case (op_i)
			ASCII_ADD_FIX, ASCII_DIFFERENCE_FIX:
			begin
				if (lo_adj)
					s1 = (op_i == ASCII_ADD_FIX) ? s1 + {1'b0, `IAU_NIB_ADJ}
						: s1 - {1'b0, `IAU_NIB_ADJ};
				al_o = {4'h0, s1[3:0]};
				af_o = lo_adj;
				cf_o = lo_adj;
			end
			PACKED_BCD_ADD_FIX:
			begin
				if (lo_adj)
					s1 = s1 + {1'b0, `IAU_NIB_ADJ};
				if (hi_adj)
					s1 = {1'b0, s1[7:0]} + {1'b0, `IAU_HI_ADJ};
				al_o = s1[7:0];
				af_o = lo_adj;
				cf_o = hi_adj | (lo_adj & (al_i > 8'hf9));
			end
			PACKED_BCD_DIFFERENCE_FIX:
			begin
				if (lo_adj)
					s1 = s1 - {1'b0, `IAU_NIB_ADJ};
				if (hi_adj)
					s1 = {1'b0, s1[7:0]} - {1'b0, `IAU_HI_ADJ};
				al_o = s1[7:0];
				af_o = lo_adj;
				cf_o = hi_adj | (lo_adj & (al_i < `IAU_NIB_ADJ));
			end
			default:
			begin
				al_o = al_i;
			end
		endcase
	end

endmodule // iau_decimal_adjust

`default_nettype wire

// *** iau_divider.sv ***
// Restoring divider for unsigned and signed byte or word division with
// quotient range check; one quotient bit per enabled clock.
// Assumes operands are valid on the cycle of start_i only.
`timescale 1ns/1ps
`default_nettype none

module iau_divider #(
	parameter int W = 16
) (
	input  wire logic           clk_i,
	input  wire logic           rst_n_i,
	input  wire logic           ce_i,
	input  wire logic           start_i,
	input  wire logic           signed_i,
	input  wire logic           word_i,
	input  wire logic [2*W-1:0] dividend_i,
	input  wire logic [W-1:0]   divisor_i,
	output logic                done_o,
	output logic                err_o,
	output logic [W-1:0]        quot_o,
	output logic [W-1:0]        rem_o
);
	localparam int H  = W / 2;
	localparam int CW = $clog2(2 * W) + 1;

	logic [2*W-1:0] dvd_full;
	logic [2*W-1:0] dvd_mag;
	logic [W-1:0]   dvs_full;
	logic [W-1:0]   dvs_mag;
	logic [W:0]     shifted;
	logic [W-1:0]   lim;
	logic [2*W-1:0] q_q;
	logic [W-1:0]   r_q;
	logic [W-1:0]   d_q;
	logic [CW-1:0]  cnt_q;
	logic           busy_q;
	logic           qneg_q;
	logic           rneg_q;
	logic           word_q;
	logic           sgn_q;

	always_comb
	begin
		dvd_full = word_i ? dividend_i
			: {{W{signed_i & dividend_i[W-1]}}, dividend_i[W-1:0]};
		dvs_full = word_i ? divisor_i
			: {{H{signed_i & divisor_i[H-1]}}, divisor_i[H-1:0]};
		dvd_mag  = (signed_i & dvd_full[2*W-1]) ? ~dvd_full + 1'b1 : dvd_full;
		dvs_mag  = (signed_i & dvs_full[W-1]) ? ~dvs_full + 1'b1 : dvs_full;
		shifted  = {r_q, q_q[2*W-1]};
		if (sgn_q)
			lim = word_q ? {1'b0, {(W-1){1'b1}}} : {{(H+1){1'b0}}, {(H-1){1'b1}}};
		else
			lim = word_q ? {W{1'b1}} : {{H{1'b0}}, {H{1'b1}}};
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			q_q    <= '0;
			r_q    <= '0;
			d_q    <= '0;
			cnt_q  <= '0;
			busy_q <= 1'b0;
			qneg_q <= 1'b0;
			rneg_q <= 1'b0;
			word_q <= 1'b0;
			sgn_q  <= 1'b0;
			done_o <= 1'b0;
			err_o  <= 1'b0;
			quot_o <= '0;
			rem_o  <= '0;
		end
		else if (ce_i)
		begin
			done_o <= 1'b0;
			if (start_i && !busy_q)
			begin
				q_q    <= dvd_mag;
				r_q    <= '0;
				d_q    <= dvs_mag;
				cnt_q  <= CW'(2 * W);
				busy_q <= 1'b1;
				qneg_q <= signed_i & (dvd_full[2*W-1] ^ dvs_full[W-1]);
				rneg_q <= signed_i & dvd_full[2*W-1];
				word_q <= word_i;
				sgn_q  <= signed_i;
			end
			else if (busy_q && cnt_q != '0)
			begin
				if (shifted >= {1'b0, d_q})
				begin
					r_q <= W'(shifted - {1'b0, d_q});
					q_q <= {q_q[2*W-2:0], 1'b1};
				end
				else
				begin
					r_q <= shifted[W-1:0];
					q_q <= {q_q[2*W-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 1'b1;
			end
			else if (busy_q)
			begin
				busy_q <= 1'b0;
				done_o <= 1'b1;
				err_o  <= (d_q == '0) || (q_q > {{W{1'b0}}, lim});
				quot_o <= qneg_q ? ~q_q[W-1:0] + 1'b1 : q_q[W-1:0];
				rem_o  <= rneg_q ? ~r_q + 1'b1 : r_q;
			end
		end
	end

endmodule // iau_divider

`default_nettype wire

// *** iau_arith_unit.sv ***
// Integer arithmetic execution unit: add, subtract, compare, negate,
// multiply, divide, decimal adjust and sign extension with six status flags.
// Assumes the decoder drives requests synchronous to MCLK_I and an AXI4-Lite
// master reaches the flags and status registers.
`timescale 1ns/1ps
`default_nettype none
`include "iau_defs.svh"

// Behaviour
// - Add writes the sum and updates all six flags.
// - Add with carry adds one more when carry is set; six flags updated.
// - Plus one updates five flags, carry kept.
// - ASCII add fix makes low byte an unpacked digit; half-carry and carry.
// - Packed add fix makes two packed digits; five flags, overflow kept.
// - Subtract writes the difference and updates all six flags.
// - Subtract with borrow removes one more when carry set; six flags.
// - Minus one updates five flags, carry kept.
// - Negate gives zero minus operand; most negative value sets overflow.
// - Negate sets carry unless the operand was zero.
// - Compare sets flags as subtract but writes nothing back.
// - ASCII subtract fix makes low byte an unpacked digit.
// - Packed subtract fix makes two packed digits; five flags.
// - Unsigned multiply; carry and overflow when upper half nonzero.
// - Signed multiply; carry and overflow when upper half is not sign fill.
// - ASCII product fix splits low byte into two unpacked digits.
// - Unsigned divide gives truncated quotient and remainder.
// - Quotient over capacity, or divide by zero, raises divide error.
// - Signed quotient limits are 81h..7Fh and 8001h..7FFFh.
// - Signed quotient truncates toward zero; remainder takes dividend sign.
// - ASCII quotient prep folds two digits into a binary low byte.
// - Sign extension fills high byte or extension word; flags untouched.
// - Half-carry marks a carry out of or borrow into the low nibble.
// - Sign equals bit 7 for bytes, bit 15 for words.
// - Parity set when the low eight result bits hold even ones.
// - Overflow set when the signed result does not fit.
module iau_arith_unit
	import iau_pkg::*;
(
	input  wire logic                      MCLK_I,
	input  wire logic                      RESET_N_I,
	input  wire logic                      CE_I,
	input  wire logic                      START_I,
	input  wire iau_pkg::iau_req_s         REQ_I,
	output logic                           DONE_O,
	output logic                           BUSY_O,
	output iau_pkg::iau_rsp_s              RSP_O,
	output iau_pkg::iau_flags_s            FLAGS_O,
	output logic                           DIV_ERR_O,
	input  wire logic                      S_AXI_AWVALID_I,
	output logic                           S_AXI_AWREADY_O,
	input  wire logic [`IAU_AXI_AW-1:0]    S_AXI_AWADDR_I,
	input  wire logic                      S_AXI_WVALID_I,
	output logic                           S_AXI_WREADY_O,
	input  wire logic [31:0]               S_AXI_WDATA_I,
	input  wire logic [3:0]                S_AXI_WSTRB_I,
	output logic                           S_AXI_BVALID_O,
	input  wire logic                      S_AXI_BREADY_I,
	output logic [1:0]                     S_AXI_BRESP_O,
	input  wire logic                      S_AXI_ARVALID_I,
	output logic                           S_AXI_ARREADY_O,
	input  wire logic [`IAU_AXI_AW-1:0]    S_AXI_ARADDR_I,
	output logic                           S_AXI_RVALID_O,
	input  wire logic                      S_AXI_RREADY_I,
	output logic [31:0]                    S_AXI_RDATA_O,
	output logic [1:0]                     S_AXI_RRESP_O
);
	iau_state_e             state_q;
	iau_flags_s             flags_q;
	iau_flags_s             nf;
	iau_rsp_s               rsp_d;
	logic                   div_err_seen_q;
	logic                   div_word_q;
	logic                   is_div;
	logic                   div_start;
	logic                   div_done;
	logic                   div_err;
	logic [15:0]            div_quot;
	logic [15:0]            div_rem;
	logic [15:0]            a;
	logic [15:0]            b;
	logic [15:0]            acc;
	logic                   cin;
	logic                   is_sub;
	logic [16:0]            sum;
	logic                   msb_a;
	logic                   msb_b;
	logic                   msb_r;
	logic                   cout;
	logic                   ovf;
	logic                   half;
	logic [31:0]            uprod;
	logic signed [31:0]     sprod_w;
	logic signed [15:0]     sprod_b;
	logic [7:0]             adj_al;
	logic                   adj_af;
	logic                   adj_cf;
	logic [7:0]             prep_al;
	logic [7:0]             prod_hi;
	logic [7:0]             prod_lo;
	logic                   aw_have;
	logic                   w_have;
	logic [`IAU_AXI_AW-1:0] aw_addr_q;
	logic [31:0]            w_data_q;
	logic [3:0]             w_strb_q;
	logic                   wr_fire;
	logic                   wr_flags;

	// Sign, zero and parity of a result of the given width
	function automatic iau_flags_s szp(iau_flags_s f, logic [15:0] r, logic w);
		iau_flags_s o;
		o           = f;
		o.sign_flag = w ? r[15] : r[7];
		o.zero_flag = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
		o.parity_flag = ~^r[7:0];
		return o;
	endfunction

	assign acc       = REQ_I.accumulator_word;
	assign is_div    = (REQ_I.op == UNSIGNED_QUOTIENT_OP) || (REQ_I.op == SIGNED_QUOTIENT_OP);
	assign div_start = (state_q == ST_IDLE) && START_I && is_div;

	iau_divider #(
		.W (16)
	) u_divider (
		.clk_i      (MCLK_I),
		.rst_n_i    (RESET_N_I),
		.ce_i       (CE_I),
		.start_i    (div_start),
		.signed_i   (REQ_I.op == SIGNED_QUOTIENT_OP),
		.word_i     (REQ_I.word),
		.dividend_i ({REQ_I.extension_word, acc}),
		.divisor_i  (REQ_I.src),
		.done_o     (div_done),
		.err_o      (div_err),
		.quot_o     (div_quot),
		.rem_o      (div_rem)
	);

	iau_decimal_adjust u_decimal_adjust (
		.op_i (REQ_I.op),
		.al_i (acc[7:0]),
		.af_i (flags_q.half_carry_flag),
		.cf_i (flags_q.carry_flag),
		.al_o (adj_al),
		.af_o (adj_af),
		.cf_o (adj_cf)
	);

	// Shared adder for add, subtract, compare and negate
	always_comb
	begin
		a      = REQ_I.dst;
		b      = REQ_I.src;
		cin    = 1'b0;
		is_sub = 1'b0;
		case (REQ_I.op)
			ADD_CARRY_OP:
				cin = flags_q.carry_flag;
			PLUS_ONE_OP:
				b = 16'h0001;
			DIFFERENCE_OP, COMPARE_OP:
				is_sub = 1'b1;
			DIFFERENCE_WITH_BORROW:
			begin
				is_sub = 1'b1;
				cin    = flags_q.carry_flag;
			end
			MINUS_ONE_OP:
			begin
				is_sub = 1'b1;
				b      = 16'h0001;
			end
			TWOS_COMPLEMENT_OP:
			begin
				is_sub = 1'b1;
				a      = 16'h0000;
				b      = REQ_I.dst;
			end
			default:
				cin = 1'b0;
		endcase
		if (!REQ_I.word)
		begin
			a = {8'h00, a[7:0]};
			b = {8'h00, b[7:0]};
		end
		sum = is_sub ? {1'b0, a} - {1'b0, b} - {16'h0000, cin}
			: {1'b0, a} + {1'b0, b} + {16'h0000, cin};
		msb_a = REQ_I.word ? a[15] : a[7];
		msb_b = REQ_I.word ? b[15] : b[7];
		msb_r = REQ_I.word ? sum[15] : sum[7];
		cout  = REQ_I.word ? sum[16] : sum[8];
		half  = a[4] ^ b[4] ^ sum[4];
		ovf   = is_sub ? (msb_a != msb_b) && (msb_r != msb_a)
			: (msb_a == msb_b) && (msb_r != msb_a);
	end

	// Products and ASCII multiply and divide helpers
	always_comb
	begin
		uprod   = REQ_I.word ? 32'(acc) * 32'(REQ_I.src)
			: {16'h0000, 16'(acc[7:0]) * 16'(REQ_I.src[7:0])};
		sprod_w = $signed(acc) * $signed(REQ_I.src);
		sprod_b = $signed(acc[7:0]) * $signed(REQ_I.src[7:0]);
		prod_hi = acc[7:0] / `IAU_TEN;
		prod_lo = acc[7:0] % `IAU_TEN;
		prep_al = 8'(acc[15:8] * `IAU_TEN + acc[7:0]);
	end

	// Result and flag selection; flags not named keep their value
	always_comb
	begin
		nf    = flags_q;
		rsp_d = RSP_O;
		rsp_d.wr_dst = 1'b0;
		rsp_d.wr_acc = 1'b0;
		rsp_d.wr_ext = 1'b0;
		case (REQ_I.op)
			ADD_OP, ADD_CARRY_OP, DIFFERENCE_OP, DIFFERENCE_WITH_BORROW,
			TWOS_COMPLEMENT_OP, COMPARE_OP:
			begin
				nf = szp(flags_q, sum[15:0], REQ_I.word);
				nf.carry_flag      = cout;
				nf.half_carry_flag = half;
				nf.overflow_flag   = ovf;
				rsp_d.dst    = REQ_I.word ? sum[15:0] : {8'h00, sum[7:0]};
				rsp_d.wr_dst = (REQ_I.op != COMPARE_OP);
			end
			PLUS_ONE_OP, MINUS_ONE_OP:
			begin
				nf = szp(flags_q, sum[15:0], REQ_I.word);
				nf.half_carry_flag = half;
				nf.overflow_flag   = ovf;
				rsp_d.dst    = REQ_I.word ? sum[15:0] : {8'h00, sum[7:0]};
				rsp_d.wr_dst = 1'b1;
			end
			ASCII_ADD_FIX, ASCII_DIFFERENCE_FIX:
			begin
				nf.half_carry_flag = adj_af;
				nf.carry_flag      = adj_cf;
				rsp_d.accumulator_word = {acc[15:8], adj_al};
				rsp_d.wr_acc = 1'b1;
			end
			PACKED_BCD_ADD_FIX, PACKED_BCD_DIFFERENCE_FIX:
			begin
				nf = szp(flags_q, {8'h00, adj_al}, 1'b0);
				nf.half_carry_flag = adj_af;
				nf.carry_flag      = adj_cf;
				rsp_d.accumulator_word = {acc[15:8], adj_al};
				rsp_d.wr_acc = 1'b1;
			end
			UNSIGNED_PRODUCT_OP:
			begin
				nf.carry_flag = REQ_I.word ? (uprod[31:16] != 16'h0000)
					: (uprod[15:8] != 8'h00);
				nf.overflow_flag = nf.carry_flag;
				rsp_d.accumulator_word = uprod[15:0];
				rsp_d.extension_word   = uprod[31:16];
				rsp_d.wr_acc = 1'b1;
				rsp_d.wr_ext = REQ_I.word;
			end
			SIGNED_PRODUCT_OP:
			begin
				nf.carry_flag = REQ_I.word ? (sprod_w[31:16] != {16{sprod_w[15]}})
					: (sprod_b[15:8] != {8{sprod_b[7]}});
				nf.overflow_flag = nf.carry_flag;
				rsp_d.accumulator_word = REQ_I.word ? sprod_w[15:0] : sprod_b;
				rsp_d.extension_word   = sprod_w[31:16];
				rsp_d.wr_acc = 1'b1;
				rsp_d.wr_ext = REQ_I.word;
			end
			ASCII_PRODUCT_FIX:
			begin
				nf = szp(flags_q, {8'h00, prod_lo}, 1'b0);
				rsp_d.accumulator_word = {prod_hi, prod_lo};
				rsp_d.wr_acc = 1'b1;
			end
			ASCII_QUOTIENT_PREP:
			begin
				nf = szp(flags_q, {8'h00, prep_al}, 1'b0);
				rsp_d.accumulator_word = {8'h00, prep_al};
				rsp_d.wr_acc = 1'b1;
			end
			BYTE_SIGN_EXTEND:
			begin
				rsp_d.accumulator_word = {{8{acc[7]}}, acc[7:0]};
				rsp_d.wr_acc = 1'b1;
			end
			WORD_SIGN_EXTEND:
			begin
				rsp_d.extension_word = {16{acc[15]}};
				rsp_d.wr_ext = 1'b1;
			end
			default:
				nf = flags_q;
		endcase
	end

	// Control: single cycle ops answer next edge, divide waits on the divider
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			state_q    <= ST_IDLE;
			DONE_O     <= 1'b0;
			BUSY_O     <= 1'b0;
			DIV_ERR_O  <= 1'b0;
			div_word_q <= 1'b0;
		end
		else if (CE_I)
		begin
			DONE_O    <= 1'b0;
			DIV_ERR_O <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (div_start)
					begin
						state_q    <= ST_DIVIDE;
						BUSY_O     <= 1'b1;
						div_word_q <= REQ_I.word;
					end
					else if (START_I)
						DONE_O <= 1'b1;
				end
				ST_DIVIDE:
				begin
					if (div_done)
					begin
						state_q   <= ST_IDLE;
						BUSY_O    <= 1'b0;
						DONE_O    <= 1'b1;
						DIV_ERR_O <= div_err;
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Answer register
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			RSP_O <= '0;
		else if (CE_I)
		begin
			if (state_q == ST_IDLE && START_I && !is_div)
				RSP_O <= rsp_d;
			else if (state_q == ST_DIVIDE && div_done)
			begin
				RSP_O.wr_dst <= 1'b0;
				RSP_O.wr_acc <= !div_err;
				RSP_O.wr_ext <= !div_err && div_word_q;
				RSP_O.accumulator_word <= div_word_q ? div_quot
					: {div_rem[7:0], div_quot[7:0]};
				RSP_O.extension_word   <= div_rem;
			end
		end
	end

	// Flags; a finishing operation wins over a software write
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			flags_q <= `IAU_FLAGS_RST;
		else if (CE_I)
		begin
			if (state_q == ST_IDLE && START_I && !is_div)
				flags_q <= nf;
			else if (wr_flags)
				flags_q <= w_data_q[5:0];
		end
	end

	assign FLAGS_O = flags_q;

	// Divide error seen, held until the next divide starts
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			div_err_seen_q <= 1'b0;
		else if (CE_I)
		begin
			if (state_q == ST_DIVIDE && div_done)
				div_err_seen_q <= div_err;
			else if (div_start)
				div_err_seen_q <= 1'b0;
		end
	end

	// AXI4-Lite write channel
	assign aw_have  = !S_AXI_AWREADY_O;
	assign w_have   = !S_AXI_WREADY_O;
	assign wr_fire  = aw_have && w_have && !S_AXI_BVALID_O;
	assign wr_flags = wr_fire && ({aw_addr_q[3:2], 2'b00} == `IAU_OFS_FLAGS) && w_strb_q[0];

	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			S_AXI_AWREADY_O <= 1'b1;
			S_AXI_WREADY_O  <= 1'b1;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= `IAU_RESP_OKAY;
			aw_addr_q       <= '0;
			w_data_q        <= '0;
			w_strb_q        <= '0;
		end
		else if (CE_I)
		begin
			if (S_AXI_AWREADY_O && S_AXI_AWVALID_I)
			begin
				aw_addr_q       <= S_AXI_AWADDR_I;
				S_AXI_AWREADY_O <= 1'b0;
			end
			if (S_AXI_WREADY_O && S_AXI_WVALID_I)
			begin
				w_data_q       <= S_AXI_WDATA_I;
				w_strb_q       <= S_AXI_WSTRB_I;
				S_AXI_WREADY_O <= 1'b0;
			end
			if (wr_fire)
			begin
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O  <= ({aw_addr_q[3:2], 2'b00} == `IAU_OFS_FLAGS ||
					{aw_addr_q[3:2], 2'b00} == `IAU_OFS_STATUS) ? `IAU_RESP_OKAY
					: `IAU_RESP_SLVERR;
			end
			if (S_AXI_BVALID_O && S_AXI_BREADY_I)
			begin
				S_AXI_BVALID_O  <= 1'b0;
				S_AXI_AWREADY_O <= 1'b1;
				S_AXI_WREADY_O  <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge MCLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= '0;
			S_AXI_RRESP_O   <= `IAU_RESP_OKAY;
		end
		else if (CE_I)
		begin
			if (S_AXI_ARREADY_O && S_AXI_ARVALID_I)
			begin
				S_AXI_ARREADY_O <= 1'b0;
				S_AXI_RVALID_O  <= 1'b1;
				S_AXI_RRESP_O   <= `IAU_RESP_OKAY;
				S_AXI_RDATA_O   <= '0;
				case ({S_AXI_ARADDR_I[3:2], 2'b00})
					`IAU_OFS_FLAGS:
						S_AXI_RDATA_O <= {26'h0000000, flags_q};
					`IAU_OFS_STATUS:
					begin
						S_AXI_RDATA_O[`IAU_ST_BUSY_BIT] <= BUSY_O;
						S_AXI_RDATA_O[`IAU_ST_DERR_BIT] <= div_err_seen_q;
					end
					default:
						S_AXI_RRESP_O <= `IAU_RESP_SLVERR;
				endcase
			end
			if (S_AXI_RVALID_O && S_AXI_RREADY_I)
			begin
				S_AXI_RVALID_O  <= 1'b0;
				S_AXI_ARREADY_O <= 1'b1;
			end
		end
	end

endmodule // iau_arith_unit

`default_nettype wire

// *** iau_arith_unit_properties.sv ***
// Timing and flag checks on the arithmetic unit's decoder side.
// Assumes binding to iau_arith_unit, one clock, reset active low.
`timescale 1ns/1ps
`default_nettype none

module iau_chk
	import iau_pkg::*;
(
	input wire logic              MCLK_I,
	input wire logic              RESET_N_I,
	input wire logic              CE_I,
	input wire logic              START_I,
	input wire iau_pkg::iau_req_s REQ_I,
	input wire logic              DONE_O,
	input wire logic              BUSY_O,
	input wire iau_pkg::iau_rsp_s RSP_O,
	input wire iau_pkg::iau_flags_s FLAGS_O,
	input wire logic              DIV_ERR_O
);
	wire tk = CE_I && START_I && !BUSY_O;
	wire dv = tk && REQ_I.op inside {UNSIGNED_QUOTIENT_OP, SIGNED_QUOTIENT_OP};
	wire inc = tk && REQ_I.op inside {PLUS_ONE_OP, MINUS_ONE_OP};
	wire ext = tk && REQ_I.op inside {BYTE_SIGN_EXTEND, WORD_SIGN_EXTEND};
	wire neg = tk && REQ_I.op == TWOS_COMPLEMENT_OP;
	wire cmp = tk && REQ_I.op == COMPARE_OP;
	wire add = tk && REQ_I.op == ADD_OP;
	wire nz = REQ_I.word ? REQ_I.dst != 16'h0000 : REQ_I.dst[7:0] != 8'h00;
	wire w = REQ_I.word;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);
	a_quick_answer: assert property (tk && !dv |=> DONE_O)
		else $error("no answer after take");
	a_div_latency: assert property (dv |-> ##[34:35] DONE_O)
		else $error("divide answer late");
	a_div_busy: assert property (dv |=> BUSY_O [*8])
		else $error("busy missing in divide");
	a_err_nowrite: assert property (DIV_ERR_O |-> DONE_O && !RSP_O.wr_acc && !RSP_O.wr_ext)
		else $error("divide error wrote back");
	a_carry_kept: assert property (inc |=> FLAGS_O.carry_flag == $past(FLAGS_O.carry_flag))
		else $error("carry changed by step op");
	a_ext_flags: assert property (ext |=> $stable(FLAGS_O))
		else $error("sign extend moved flags");
	a_neg_carry: assert property (neg |=> FLAGS_O.carry_flag == $past(nz))
		else $error("negate carry wrong");
	a_cmp_keep: assert property (cmp |=> !RSP_O.wr_dst)
		else $error("compare wrote back");
	a_add_parity: assert property (add |=> FLAGS_O.parity_flag == ~^RSP_O.dst[7:0])
		else $error("parity wrong");
	a_add_sign: assert property (add |=> FLAGS_O.sign_flag == ($past(w) ? RSP_O.dst[15] : RSP_O.dst[7]))
		else $error("sign wrong");
	cover property (DIV_ERR_O);
	cover property (dv);
	cover property (DONE_O && RSP_O.wr_ext);
endmodule // iau_chk

bind iau_arith_unit iau_chk chk_u(.MCLK_I, .RESET_N_I, .CE_I, .START_I, .REQ_I, .DONE_O,
	.BUSY_O, .RSP_O, .FLAGS_O, .DIV_ERR_O);
`default_nettype wire

// *** iau_dec_model.sv ***
// Decoder model: issues one request and holds it until the answer.
// Assumes DONE from the unit and a free running clock.
`timescale 1ns/1ps
`default_nettype none

module iau_dec_model
	import iau_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              done_i,
	output logic                   start_o,
	output iau_pkg::iau_req_s      req_o
);
	initial
	begin
		start_o = 1'b0;
		req_o = '0;
	end
	task automatic issue(input iau_req_s r);
		@(posedge clk_i);
		start_o <= 1'b1;
		req_o <= r;
		@(posedge clk_i);
		start_o <= 1'b0;
		do @(posedge clk_i); while (!done_i);
		req_o <= ~r;
	endtask
endmodule // iau_dec_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the arithmetic unit.
// Assumes the decoder model and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import iau_pkg::*;
	logic MCLK_I = 0, RESET_N_I = 0, aw = 0, w = 0, ar = 0, br = 0, rr = 0;
	logic [3:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdata;
	logic [1:0] bresp, rresp;
	logic START_I, DONE_O, BUSY_O, DIV_ERR_O, awrdy, wrdy, bv, arrdy, rv;
	int num_errors = 0, checked = 0, cyc = 0;
	iau_req_s REQ_I;
	iau_rsp_s RSP_O;
	iau_flags_s FLAGS_O;
	always #12.5 MCLK_I = ~MCLK_I;
	iau_dec_model dec_u(.clk_i(MCLK_I), .done_i(DONE_O), .start_o(START_I), .req_o(REQ_I));
	iau_arith_unit dut_u(.MCLK_I, .RESET_N_I, .CE_I(1'b1), .START_I, .REQ_I, .DONE_O, .BUSY_O,
		.RSP_O, .FLAGS_O, .DIV_ERR_O, .S_AXI_AWVALID_I(aw), .S_AXI_AWREADY_O(awrdy),
		.S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(w), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp),
		.S_AXI_ARVALID_I(ar), .S_AXI_ARREADY_O(arrdy), .S_AXI_ARADDR_I(ara),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp));
	task automatic summarize;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t(string n, logic [31:0] g, logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic put(logic [3:0] a, logic [31:0] d, logic [1:0] er);
		logic pa, pw;
		pa = 1;
		pw = 1;
		@(posedge MCLK_I);
		aw <= 1; w <= 1; awa <= a; wd <= d; br <= 1;
		while (pa || pw)
		begin
			@(posedge MCLK_I);
			if (pa && awrdy) begin pa = 0; aw <= 0; end
			if (pw && wrdy) begin pw = 0; w <= 0; end
		end
		do @(posedge MCLK_I); while (!bv);
		br <= 0;
		t("bresp", bresp, er);
	endtask
	task automatic get(logic [3:0] a, logic [31:0] ed, logic [1:0] er);
		@(posedge MCLK_I);
		ar <= 1; ara <= a; rr <= 1;
		do @(posedge MCLK_I); while (!arrdy);
		ar <= 0;
		do @(posedge MCLK_I); while (!rv);
		rr <= 0;
		t("rdata", rdata, ed);
		t("rresp", rresp, er);
	endtask
	// Issue one op; k picks dst, acc, ext:acc, wr_dst or the write enables
	task automatic x(iau_op_e o, logic wo, logic [15:0] d, logic [15:0] s, logic [15:0] a,
		logic [15:0] e, int k, logic [31:0] ev, logic [5:0] ef);
		dec_u.issue('{o, wo, d, s, a, e});
		t("result", k == 0 ? {16'h0, RSP_O.dst} : k == 1 ? {16'h0, RSP_O.accumulator_word} :
			k == 2 ? {RSP_O.extension_word, RSP_O.accumulator_word} :
			k == 3 ? {31'h0, RSP_O.wr_dst} : {30'h0, RSP_O.wr_acc, RSP_O.wr_ext}, ev);
		t("flags", FLAGS_O, ef);
		t("div_err", DIV_ERR_O, k == 4);
	endtask
	always @(posedge MCLK_I)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			num_errors++;
			summarize;
		end
	end
	initial
	begin
		repeat (4) @(posedge MCLK_I);
		RESET_N_I <= 1;
		get(4'h0, 32'h0, 2'h0);
		x(ADD_OP, 0, 'h7f, 'h1, 0, 0, 0, 'h80, 'h34);
		put(4'h0, 32'h1, 2'h0);
		get(4'h0, 32'h1, 2'h0);
		get(4'h8, 32'h0, 2'h2);
		x(ADD_CARRY_OP, 1, 'hffff, 0, 0, 0, 0, 0, 'h0f);
		x(PLUS_ONE_OP, 0, 'h7f, 0, 0, 0, 0, 'h80, 'h35);
		x(DIFFERENCE_WITH_BORROW, 0, 0, 0, 0, 0, 0, 'hff, 'h17);
		x(MINUS_ONE_OP, 1, 'h8000, 0, 0, 0, 0, 'h7fff, 'h27);
		x(TWOS_COMPLEMENT_OP, 0, 'h80, 0, 0, 0, 0, 'h80, 'h31);
		x(COMPARE_OP, 1, 5, 7, 0, 0, 3, 0, 'h15);
		x(UNSIGNED_PRODUCT_OP, 0, 0, 'h10, 'h10, 0, 1, 'h100, 'h35);
		x(SIGNED_PRODUCT_OP, 1, 0, 2, 'hffff, 0, 2, 'hfffffffe, 'h14);
		x(UNSIGNED_QUOTIENT_OP, 0, 0, 'h10, 'h107, 0, 1, 'h0710, 'h14);
		x(SIGNED_QUOTIENT_OP, 1, 0, 2, 'hfff9, 'hffff, 2, 'hfffffffd, 'h14);
		x(UNSIGNED_QUOTIENT_OP, 0, 0, 0, 'h107, 0, 4, 0, 'h14);
		x(SIGNED_QUOTIENT_OP, 0, 0, 1, 'hff80, 0, 4, 0, 'h14);
		get(4'h4, 32'h2, 2'h0);
		x(ASCII_PRODUCT_FIX, 0, 0, 0, 'h51, 0, 1, 'h0801, 'h04);
		x(ASCII_QUOTIENT_PREP, 0, 0, 0, 'h0705, 0, 1, 'h4b, 'h06);
		x(BYTE_SIGN_EXTEND, 0, 0, 0, 'h80, 0, 1, 'hff80, 'h06);
		x(ASCII_ADD_FIX, 0, 0, 0, 'h0b, 0, 1, 'h0001, 'h07);
		x(PACKED_BCD_ADD_FIX, 0, 0, 0, 'h9a, 0, 1, 'h0000, 'h0f);
		x(DIFFERENCE_OP, 0, 'h10, 1, 0, 0, 0, 'h0f, 'h06);
		x(ASCII_DIFFERENCE_FIX, 0, 0, 0, 'h0f, 0, 1, 'h0009, 'h07);
		x(PACKED_BCD_DIFFERENCE_FIX, 0, 0, 0, 'h66, 0, 1, 'h0000, 'h0f);
		x(WORD_SIGN_EXTEND, 1, 0, 0, 'h8000, 0, 2, 'hffff0000, 'h0f);
		summarize;
	end
endmodule // tb_top
`default_nettype wire
